/* hw/sfrp_regs.vh */
// Constants for the read-parameter register block
`ifndef SFRP_REGS_VH
`define SFRP_REGS_VH
// Opcodes
`define SFRP_OP_SET_PERSIST   8'h65
`define SFRP_OP_SET_WORK      8'hc0
`define SFRP_OP_SET_WORK_ALT  8'h63
`define SFRP_OP_FAST_READ     8'h0b
`define SFRP_OP_DUAL_OUT      8'h3b
`define SFRP_OP_DUAL_IO       8'hbb
`define SFRP_OP_QUAD_OUT      8'h6b
`define SFRP_OP_QUAD_IO       8'heb
`define SFRP_OP_FAST_READ_DR  8'h0d
`define SFRP_OP_DUAL_IO_DR    8'hbd
`define SFRP_OP_QUAD_IO_DR    8'hed
`define SFRP_OP_UNIQUE_ID     8'h4b
`define SFRP_OP_PARAM_TABLE   8'h5a
`define SFRP_OP_INFO_ROW      8'h68
// Register reset and field positions
`define SFRP_REG_RESET        8'h00
`define SFRP_PIN_ROLE_BIT     7
`define SFRP_DUMMY_HI         6
`define SFRP_DUMMY_LO         3
`define SFRP_WRAP_BIT         2
`define SFRP_BURST_HI         1
`define SFRP_BURST_LO         0
// Default dummy counts
`define SFRP_DEF_DUMMY_8      4'h8
`define SFRP_DEF_DUMMY_6      4'h6
`define SFRP_DEF_DUMMY_4      4'h4
`endif

/* hw/sfrp_sync.v */
// Two-flop synchroniser with rising edge detect
`default_nettype none
module sfrp_sync #(
  parameter [0:0] IDLE = 1'b0  // Pin level while idle
) (
  input  wire clk_i,
  input  wire srst_i,
  input  wire d_i,
  output wire q_o,
  output wire rise_o
);
  reg s1;  // First stage, read only by s2
  reg s2;  // Second stage
  reg s3;  // Previous value for edges
  // Sample chain
  always @(posedge clk_i) begin
    if (srst_i) begin
      // Idle level, so no false edge follows reset
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign q_o    = s2;
  assign rise_o = s2 & ~s3;
endmodule
`default_nettype wire

/* hw/sfrp_top.v */
// Read-parameter register with serial command capture and decode
`default_nettype none
`include "sfrp_regs.vh"
module sfrp_top (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       pwr_up_i,
  input  wire       sck_i,
  input  wire       cs_n_i,
  input  wire [3:0] dq_i,
  input  wire       quad_enable_bit_i,
  input  wire       quad_command_mode_i,
  input  wire       has_dedicated_reset_i,
  input  wire       dedicated_reset_disable_i,
  output reg  [7:0] read_param_work_o,
  output reg  [7:0] read_param_persist_o,
  output reg        pin_is_hold_o,
  output reg        pin_is_reset_o,
  output reg        pin_is_data_line_3_o,
  output reg        wrap_enable_bit_o,
  output reg  [6:0] burst_bytes_o,
  output reg  [3:0] read_dummy_o,
  output reg  [7:0] cmd_opcode_o,
  output reg        cmd_valid_o
);
  wire       sck_q;     // Synced serial clock
  wire       sck_rise;  // Serial clock rising edge
  wire       cs_q;      // Synced chip select low
  wire [3:0] dq_q;      // Synced data lines
  wire       cs_rise;   // End of frame
  wire       pwr_q;     // Synced power-up request
  wire       pwr_rise;  // Power-up event

  // Serial clock synchroniser
  sfrp_sync u_sck (.clk_i(clk_i), .srst_i(srst_i), .d_i(sck_i), .q_o(sck_q), .rise_o(sck_rise));
  // Chip select synchroniser, rise marks frame end
  sfrp_sync #(.IDLE(1'b1)) u_cs (.clk_i(clk_i), .srst_i(srst_i), .d_i(cs_n_i), .q_o(cs_q), .rise_o(cs_rise));
  // Power-up synchroniser
  sfrp_sync u_pwr (.clk_i(clk_i), .srst_i(srst_i), .d_i(pwr_up_i), .q_o(pwr_q), .rise_o(pwr_rise));

  // Data line synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_dq
      sfrp_sync u_dq (.clk_i(clk_i), .srst_i(srst_i), .d_i(dq_i[gi]), .q_o(dq_q[gi]), .rise_o());
    end
  endgenerate

  // Default dummy count for a read opcode
  function [3:0] sfrp_def_dummy;
    input [7:0] op;
    input       qmode;
    begin
      case (op)
        `SFRP_OP_FAST_READ, `SFRP_OP_FAST_READ_DR,
        `SFRP_OP_UNIQUE_ID, `SFRP_OP_PARAM_TABLE, `SFRP_OP_INFO_ROW:
          sfrp_def_dummy = qmode ? `SFRP_DEF_DUMMY_6 : `SFRP_DEF_DUMMY_8;
        `SFRP_OP_DUAL_OUT, `SFRP_OP_QUAD_OUT:
          sfrp_def_dummy = `SFRP_DEF_DUMMY_8;
        `SFRP_OP_DUAL_IO, `SFRP_OP_DUAL_IO_DR:
          sfrp_def_dummy = `SFRP_DEF_DUMMY_4;
        `SFRP_OP_QUAD_IO, `SFRP_OP_QUAD_IO_DR:
          sfrp_def_dummy = `SFRP_DEF_DUMMY_6;
        default:
          sfrp_def_dummy = `SFRP_DEF_DUMMY_8;
      endcase
    end
  endfunction

  // Frame states, one-hot
  localparam [2:0] ST_OP   = 3'b001;  // Shifting opcode
  localparam [2:0] ST_DATA = 3'b010;  // Shifting parameter byte
  localparam [2:0] ST_SKIP = 3'b100;  // Rest of frame ignored

  reg [2:0] state;       // Frame state
  reg [2:0] next_state;  // Next frame state
  reg [3:0] bit_cnt;     // Bits in current byte
  reg [7:0] shift;       // Shift register
  reg [7:0] op;          // Captured opcode
  reg [7:0] data;        // Captured parameter byte
  reg       data_ok;     // Full parameter byte seen
  reg [2:0] step;        // Bits per clock minus one
  reg [7:0] next_shift;  // Next shift value

  // Quad mode shifts four bits per clock, else one
  always @* begin
    step = quad_command_mode_i ? 3'd3 : 3'd0;
    if (quad_command_mode_i) begin
      next_shift = {shift[3:0], dq_q};
    end else begin
      next_shift = {shift[6:0], dq_q[0]};
    end
  end

  // State transition
  always @* begin
    next_state = state;
    case (state)
      ST_OP: begin
        if (sck_rise && bit_cnt + {1'b0, step} >= 4'd7) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (sck_rise && bit_cnt + {1'b0, step} >= 4'd7) begin
          next_state = ST_SKIP;
        end
      end
      ST_SKIP: next_state = ST_SKIP;
      default: next_state = ST_OP;
    endcase
  end

  // Frame capture on synced serial clock
  always @(posedge clk_i) begin
    if (srst_i || cs_q) begin
      state   <= ST_OP;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      // Cleared between frames so a cut frame cannot reuse it
      data_ok <= 1'b0;
      if (srst_i) begin
        op      <= 8'h00;
        data    <= 8'h00;
      end
    end else if (sck_rise && state != ST_SKIP) begin
      state <= next_state;
      shift <= next_shift;
      if (next_state != state) begin
        bit_cnt <= 4'h0;
        if (state == ST_OP) begin
          op      <= next_shift;
          data_ok <= 1'b0;
        end else begin
          data    <= next_shift;
          data_ok <= 1'b1;
        end
      end else begin
        bit_cnt <= bit_cnt + {1'b0, step} + 4'h1;
      end
    end
  end

  // Register copies, commit at frame end
  always @(posedge clk_i) begin
    if (srst_i) begin
      read_param_persist_o <= `SFRP_REG_RESET;
      read_param_work_o    <= `SFRP_REG_RESET;
      cmd_opcode_o         <= 8'h00;
      cmd_valid_o          <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      if (pwr_rise) begin
        read_param_work_o <= read_param_persist_o;
      end else if (cs_rise) begin
        cmd_opcode_o <= op;
        cmd_valid_o  <= (state != ST_OP) || data_ok;
        if (data_ok && op == `SFRP_OP_SET_PERSIST) begin
          read_param_persist_o <= data;
        end
        if (data_ok && (op == `SFRP_OP_SET_WORK || op == `SFRP_OP_SET_WORK_ALT)) begin
          read_param_work_o <= data;
        end
      end
    end
  end

  // Decoded settings from the working copy
  always @(posedge clk_i) begin
    if (srst_i) begin
      pin_is_hold_o        <= 1'b1;
      pin_is_reset_o       <= 1'b0;
      pin_is_data_line_3_o <= 1'b0;
      wrap_enable_bit_o    <= 1'b0;
      burst_bytes_o        <= 7'h08;
      read_dummy_o         <= `SFRP_DEF_DUMMY_8;
    end else begin
      if (quad_enable_bit_i || quad_command_mode_i) begin
        pin_is_data_line_3_o <= 1'b1;
        pin_is_hold_o        <= 1'b0;
        pin_is_reset_o       <= 1'b0;
      end else if (has_dedicated_reset_i && !dedicated_reset_disable_i) begin
        pin_is_data_line_3_o <= 1'b0;
        pin_is_hold_o        <= 1'b1;
        pin_is_reset_o       <= 1'b0;
      end else begin
        pin_is_data_line_3_o <= 1'b0;
        pin_is_hold_o        <= ~read_param_work_o[`SFRP_PIN_ROLE_BIT];
        pin_is_reset_o       <= read_param_work_o[`SFRP_PIN_ROLE_BIT];
      end
      wrap_enable_bit_o <= read_param_work_o[`SFRP_WRAP_BIT];
      burst_bytes_o <= 7'h08 << read_param_work_o[`SFRP_BURST_HI:`SFRP_BURST_LO];
      if (cmd_valid_o) begin
        read_dummy_o <= (read_param_work_o[`SFRP_DUMMY_HI:`SFRP_DUMMY_LO] != 4'h0) ?
                        read_param_work_o[`SFRP_DUMMY_HI:`SFRP_DUMMY_LO] :
                        sfrp_def_dummy(cmd_opcode_o, quad_command_mode_i);
      end
    end
  end
endmodule
`default_nettype wire

/* tb/sfrp_top_assertions.sv */
// Port checker for the read-parameter register
`default_nettype none
module sfrp_chk (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       pwr_up_i,
  input wire logic       quad_enable_bit_i,
  input wire logic       quad_command_mode_i,
  input wire logic       has_dedicated_reset_i,
  input wire logic       dedicated_reset_disable_i,
  input wire logic [7:0] read_param_work_o,
  input wire logic [7:0] read_param_persist_o,
  input wire logic       pin_is_hold_o,
  input wire logic       pin_is_reset_o,
  input wire logic       pin_is_data_line_3_o,
  input wire logic       wrap_enable_bit_o,
  input wire logic [6:0] burst_bytes_o,
  input wire logic [3:0] read_dummy_o,
  input wire logic [7:0] cmd_opcode_o,
  input wire logic       cmd_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic       q   = quad_enable_bit_i | quad_command_mode_i;      // Pin is data line
  wire logic       ded = has_dedicated_reset_i & ~dedicated_reset_disable_i;
  wire logic [3:0] fld = read_param_work_o[6:3];                      // Dummy field
  wire logic [7:0] op  = cmd_opcode_o;
  wire logic       rd  = op inside {8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb, 8'h4b, 8'h5a, 8'h68, 8'h0d, 8'hbd, 8'hed};
  wire logic       q6  = op inside {8'heb, 8'hed} ||
                         (quad_command_mode_i && op inside {8'h0b, 8'h0d, 8'h4b, 8'h5a, 8'h68});
  wire logic [3:0] df  = (op inside {8'hbb, 8'hbd}) ? 4'h4 : q6 ? 4'h6 : 4'h8;  // Default dummy
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  quad_pin_a: assert property (q[*3] |-> pin_is_data_line_3_o) else $error("pin not data line");
  reset_role_a: assert property ((!q && !ded && read_param_work_o[7])[*3] |-> pin_is_reset_o)
    else $error("pin not reset role");
  hold_role_a: assert property ((!q && (ded || !read_param_work_o[7]))[*3] |-> pin_is_hold_o)
    else $error("pin not hold role");
  burst_len_a: assert property (burst_bytes_o == 7'h08 << $past(read_param_work_o[1:0]))
    else $error("burst length wrong");
  wrap_bit_a: assert property (wrap_enable_bit_o == $past(read_param_work_o[2])) else $error("wrap wrong");
  persist_only_a: assert property (cmd_valid_o && op == 8'h65 |-> $stable(read_param_work_o))
    else $error("persistent write hit working copy");
  work_only_a: assert property (cmd_valid_o && op inside {8'hc0, 8'h63} |-> $stable(read_param_persist_o))
    else $error("working write hit persistent copy");
  dummy_field_a: assert property (cmd_valid_o && rd && fld != 4'h0 |=> read_dummy_o == $past(fld))
    else $error("dummy field not used");
  dummy_dflt_a: assert property (cmd_valid_o && rd && fld == 4'h0 |=> read_dummy_o == $past(df))
    else $error("default dummy wrong");
  pwr_load_a: assert property ($rose(pwr_up_i) |-> ##[2:6] read_param_work_o == read_param_persist_o)
    else $error("power-up load missing");
  cover property (cmd_valid_o && op == 8'h65);
  cover property (cmd_valid_o && op == 8'h63);
  cover property ($rose(pwr_up_i));
endmodule
bind sfrp_top sfrp_chk u_chk (.*);
`default_nettype wire

/* tb/sfrp_host.sv */
// Host controller model sending serial frames
`default_nettype none
module sfrp_host (
  input  wire logic       clk_i,
  output var  logic       sck_o,
  output var  logic       cs_n_o,
  output var  logic [3:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // opcode then parameter byte
  // n limits the clock count, to cut a frame short
  task automatic send(input logic [15:0] w, input logic qm, input int n = 16);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = (qm ? 3 : 15); i >= 0 && (qm ? 3 : 15) - i < n; i--) begin
      dq_o = qm ? w[i*4 +: 4] : {~w[i], ~w[i], ~w[i], w[i]};
      repeat (4) @(negedge clk_i);
      sck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sck_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    // Released lines show the inverse
    dq_o = ~dq_o;
    repeat (6) @(negedge clk_i);
  endtask
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    dq_o = 4'h0;
  end
endmodule
`default_nettype wire

/* tb/test_sfrp_top.sv */
// Self-checking bench for the read-parameter register
`default_nettype none
module test_sfrp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk_i = 1'b0;   // System clock
  logic            srst_i = 1'b1;  // Reset held at start
  logic            pwr_up = 1'b0;  // Power-up event
  logic [3:0]      sta = 4'h0;     // Quad enable, quad mode, dedicated pin, disable
  wire logic       sck, cs_n, hold, rrole, d3, wrap, cval;
  wire logic [3:0] dq, dum;
  wire logic [7:0] work, pers, opc;
  wire logic [6:0] burst;
  int              err_count = 0;
  int              cmp_count = 0;
  int              cyc = 0;
  int              nval = 0;       // Command pulses seen
  int              ew = 0;         // Model working copy
  int              ep = 0;         // Model persistent copy
  int              rops[$] = '{'h0b, 'h3b, 'hbb, 'h6b, 'heb, 'h4b, 'h5a, 'h68, 'h0d, 'hbd, 'hed};
  int              wops[$] = '{'h65, 'hc0, 'h63};
  always #10 clk_i = ~clk_i;
  // Count command pulses where they stand settled
  always @(negedge clk_i) if (cval === 1'b1) nval++;
  sfrp_host u_host (.clk_i(clk_i), .sck_o(sck), .cs_n_o(cs_n), .dq_o(dq));
  sfrp_top u_dut (.clk_i(clk_i), .srst_i(srst_i), .pwr_up_i(pwr_up), .sck_i(sck), .cs_n_i(cs_n), .dq_i(dq),
    .quad_enable_bit_i(sta[3]), .quad_command_mode_i(sta[2]), .has_dedicated_reset_i(sta[1]),
    .dedicated_reset_disable_i(sta[0]), .read_param_work_o(work), .read_param_persist_o(pers),
    .pin_is_hold_o(hold), .pin_is_reset_o(rrole), .pin_is_data_line_3_o(d3), .wrap_enable_bit_o(wrap),
    .burst_bytes_o(burst), .read_dummy_o(dum), .cmd_opcode_o(opc), .cmd_valid_o(cval));
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Decoded outputs against the model
  task chk_dec;
    logic [2:0] r;
    r = (sta[3] | sta[2]) ? 3'h1 : ((sta[1] & ~sta[0]) | ~ew[7]) ? 3'h4 : 3'h2;
    chk({wrap, burst}, {ew[2], 7'h08 << ew[1:0]});
    chk({5'h0, hold, rrole, d3}, {5'h0, r});
  endtask
  task wr(input int o, input int v);
    int n0;
    n0 = nval;
    u_host.send({o[7:0], v[7:0]}, sta[2]);
    if (o == 'h65) ep = v;
    else ew = v;
    chk(opc, o[7:0]);
    chk(8'(nval - n0), 8'h01);
    chk(pers, ep[7:0]);
    chk(work, ew[7:0]);
    chk_dec;
  endtask
  task rd(input int o);
    int e;
    int n0;
    e = (ew[6:3] != 0) ? ew[6:3] : (o inside {'hbb, 'hbd}) ? 4 :
        (o inside {'heb, 'hed} || (sta[2] && o inside {'h0b, 'h0d, 'h4b, 'h5a, 'h68})) ? 6 : 8;
    n0 = nval;
    u_host.send({o[7:0], 8'h00}, sta[2]);
    chk(opc, o[7:0]);
    chk(8'(nval - n0), 8'h01);
    chk({4'h0, dum}, e[7:0]);
  endtask
  // Cut frame: n clocks only, nothing may be written
  task cut(input int o, input int n, input int e);
    int n0;
    n0 = nval;
    u_host.send({o[7:0], 8'h3c}, sta[2], n);
    chk(8'(nval - n0), e[7:0]);
    chk(pers, ep[7:0]);
    chk(work, ew[7:0]);
  endtask
  task close_out;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    void'($urandom(32'h5f18));
    repeat (8) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk(pers, 8'h00);
    chk(work, 8'h00);
    chk_dec;
    foreach (rops[i]) rd(rops[i]);
    for (int i = 0; i < 9; i++) wr(wops[i % 3], $urandom_range(255));
    foreach (rops[i]) rd(rops[i]);
    wr('hc0, 'h7f);
    rd('h0b);
    // Pin roles over every static combination
    foreach (wops[k]) begin
      wr('hc0, k[0] ? 'h05 : 'h80);
      for (int s = 0; s < 16; s++) begin
        sta = s[3:0];
        repeat (5) @(negedge clk_i);
        chk_dec;
      end
    end
    // Quad framing and quad defaults
    sta = 4'h4;
    wr('h63, 'h00);
    rd('h0b);
    rd('heb);
    rd('h0d);
    rd('h4b);
    sta = 4'h0;
    wr('h65, 'ha5);
    wr('hc0, 'h5a);
    pwr_up = 1'b1;
    repeat (8) @(negedge clk_i);
    pwr_up = 1'b0;
    ew = ep;
    chk(work, ew[7:0]);
    chk_dec;
    // Frames cut inside the opcode and inside the data byte
    cut('hc0, 4, 0);
    cut('h65, 12, 1);
    close_out;
  end
endmodule
`default_nettype wire
